/* File: include/jtag_char_fifo_pkg.sv */
package jtag_char_fifo_pkg;

   localparam int DATA_W = 32;
   localparam int CHAR_W = 8;
   localparam int DEPTH_MIN = 8;
   localparam int DEPTH_MAX = 32768;
   localparam int DEPTH_DEFAULT = 64;
   localparam int LEVEL_W = 16;
   localparam logic [LEVEL_W-1:0] THRESH_DEFAULT = 16'h0008;
   localparam int PRELOAD_MAX_CHARS = 16;
   localparam int PRELOAD_IDX_W = 5;
   localparam logic [DATA_W-CHAR_W-1:0] DATA_PAD = 24'h000000;

   typedef enum logic [1:0] {
      SIM_NONE = 2'b00,
      SIM_OUTPUT = 2'b01,
      SIM_INTERACTIVE = 2'b10
   } sim_console_t;

   typedef enum logic [0:0] {
      ST_PRELOAD = 1'b0,
      ST_RUN = 1'b1
   } load_phase_t;

   typedef struct packed {
      logic valid;
      logic [CHAR_W-1:0] data;
   } char_beat_t;

   // Rounds a requested depth up to a power of two inside the legal range
   function automatic int legal_depth(input int req);
      int d;
      d = DEPTH_MIN;
      while (d < req && d < DEPTH_MAX) begin
         d = d * 2;
      end
      return d;
   endfunction : legal_depth

endpackage : jtag_char_fifo_pkg

/* File: src/char_fifo.sv */
`timescale 1ns/1ns
module char_fifo
   import jtag_char_fifo_pkg::*;
#(
   parameter int WIDTH = CHAR_W,
   parameter int DEPTH = DEPTH_DEFAULT,
   parameter bit USE_REGS = 1'b0
) (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in,
   output logic [$clog2(DEPTH):0] count_out
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
      logic full;
      logic out_valid;
      logic [WIDTH-1:0] out_data;
   } fifo_state_t;

   fifo_state_t state;
   fifo_state_t next_state;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;
   logic load;
   logic [AW:0] mem_count;

   always_comb begin
      next_state = state;
      push = in_valid_in && !state.full;
      pop = state.out_valid && out_ready_in;
      mem_count = state.count - (AW+1)'(state.out_valid);
      load = (mem_count != '0) && (!state.out_valid || pop);
      if (push) begin
         next_state.wptr = state.wptr + 1'b1;
      end
      // Head word sits in a register so downstream sees stable data
      if (load) begin
         next_state.out_data = mem[state.rptr];
         next_state.rptr = state.rptr + 1'b1;
         next_state.out_valid = 1'b1;
      end else if (pop) begin
         next_state.out_valid = 1'b0;
      end
      next_state.count = state.count + (AW+1)'(push) - (AW+1)'(pop);
      next_state.full = (next_state.count == DEPTH_CNT);
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // Register build resets its storage; block RAM cannot, but nothing reads stale words
   generate
      if (USE_REGS) begin : g_regs
         always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
               for (int i = 0; i < DEPTH; i++) begin
                  mem[i] <= '0;
               end
            end else if (push) begin
               mem[state.wptr] <= in_data_in;
            end
         end
      end else begin : g_ram
         always_ff @(posedge clk_sys_in) begin
            if (push) begin
               mem[state.wptr] <= in_data_in;
            end
         end
      end
   endgenerate

   assign in_ready_out = !state.full;
   assign out_valid_out = state.out_valid;
   assign out_data_out = state.out_data;
   assign count_out = state.count;

endmodule : char_fifo

/* File: src/jtag_char_fifo_pair.sv */
`timescale 1ns/1ns
// How it works
// - Write depth power of two, 8 to 32768
// - Read depth likewise, chosen independently
// - Bus writes fill write queue, link drains
// - Link fills read queue, bus reads pop
// - Interrupt when write level is at or below threshold
// - Interrupt when read free space reaches threshold
// - Storage as flops or RAM, same behaviour
// - Sixty-four bytes is the default depth
// - Simulation preload string fills read queue
// - Simulation options default off for hardware
// - Interactive console feeds read queue, skips preload
// - Output console echoes every accepted bus write
// - One byte per entry, low bits of word
// - Interrupt output is active high
module jtag_char_fifo_pair
   import jtag_char_fifo_pkg::*;
#(
   parameter int WR_DEPTH_REQ = DEPTH_DEFAULT,
   parameter int RD_DEPTH_REQ = DEPTH_DEFAULT,
   parameter bit USE_REGS = 1'b0,
   parameter sim_console_t SIM_MODE = SIM_NONE,
   parameter bit PRELOAD_EN = 1'b0,
   parameter int PRELOAD_LEN = 0,
   parameter logic [8*PRELOAD_MAX_CHARS-1:0] PRELOAD_TEXT = '0
) (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic bus_wr_valid_in,
   input wire logic [DATA_W-1:0] bus_wr_data_in,
   output logic bus_wr_ready_out,
   output logic bus_rd_valid_out,
   output logic [DATA_W-1:0] bus_rd_data_out,
   input wire logic bus_rd_pop_in,
   output char_beat_t jtag_tx_out,
   input wire logic jtag_tx_ready_in,
   input wire char_beat_t jtag_rx_in,
   output logic jtag_rx_ready_out,
   input wire logic [LEVEL_W-1:0] wr_threshold_in,
   input wire logic [LEVEL_W-1:0] rd_threshold_in,
   output logic [LEVEL_W-1:0] wr_level_out,
   output logic [LEVEL_W-1:0] rd_level_out,
   output logic irq_out,
   input wire char_beat_t sim_console_in,
   output logic sim_console_ready_out,
   output char_beat_t sim_echo_out
);
   localparam int WR_DEPTH = legal_depth(WR_DEPTH_REQ);
   localparam int RD_DEPTH = legal_depth(RD_DEPTH_REQ);
   localparam int WR_AW = $clog2(WR_DEPTH);
   localparam int RD_AW = $clog2(RD_DEPTH);
   localparam logic [LEVEL_W:0] RD_DEPTH_LVL = (LEVEL_W+1)'(RD_DEPTH);
   localparam logic [PRELOAD_IDX_W-1:0] PRELOAD_END = PRELOAD_IDX_W'(PRELOAD_LEN);
   // Preload only when chosen and not overridden by the live console
   localparam bit DO_PRELOAD = PRELOAD_EN && (SIM_MODE != SIM_INTERACTIVE)
      && (PRELOAD_LEN > 0);

   typedef struct packed {
      load_phase_t phase;
      logic [PRELOAD_IDX_W-1:0] idx;
      logic irq;
      logic link_open;
      logic console_open;
      logic link_ready;
      logic console_ready;
      char_beat_t echo;
      logic [LEVEL_W-1:0] wr_level;
      logic [LEVEL_W-1:0] rd_level;
   } top_state_t;

   top_state_t state;
   top_state_t next_state;

   logic tx_in_ready;
   logic tx_out_valid;
   logic [CHAR_W-1:0] tx_out_data;
   logic [WR_AW:0] tx_count;
   logic rx_in_valid;
   logic [CHAR_W-1:0] rx_in_data;
   logic rx_in_ready;
   logic rx_out_valid;
   logic [CHAR_W-1:0] rx_out_data;
   logic [RD_AW:0] rx_count;
   logic [LEVEL_W-1:0] wr_level_now;
   logic [LEVEL_W-1:0] rd_level_now;
   logic [LEVEL_W:0] rd_space;
   logic [LEVEL_W:0] rx_next_count;
   logic wr_accept;

   function automatic logic [CHAR_W-1:0] preload_char(input logic [PRELOAD_IDX_W-1:0] i);
      int pos;
      pos = PRELOAD_LEN - 1 - int'(i);
      if (pos < 0) begin
         pos = 0;
      end
      return PRELOAD_TEXT[8*pos +: 8];
   endfunction : preload_char

   // Write queue: bus side fills, link side drains
   char_fifo #(
      .WIDTH(CHAR_W),
      .DEPTH(WR_DEPTH),
      .USE_REGS(USE_REGS)
   ) u_tx_fifo (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .in_valid_in(bus_wr_valid_in),
      .in_data_in(bus_wr_data_in[CHAR_W-1:0]),
      .in_ready_out(tx_in_ready),
      .out_valid_out(tx_out_valid),
      .out_data_out(tx_out_data),
      .out_ready_in(jtag_tx_ready_in),
      .count_out(tx_count)
   );

   // Read queue: link side (or simulation source) fills, bus reads pop
   char_fifo #(
      .WIDTH(CHAR_W),
      .DEPTH(RD_DEPTH),
      .USE_REGS(USE_REGS)
   ) u_rx_fifo (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .in_valid_in(rx_in_valid),
      .in_data_in(rx_in_data),
      .in_ready_out(rx_in_ready),
      .out_valid_out(rx_out_valid),
      .out_data_out(rx_out_data),
      .out_ready_in(bus_rd_pop_in),
      .count_out(rx_count)
   );

   always_comb begin
      rx_in_valid = 1'b0;
      rx_in_data = '0;
      if (state.phase == ST_PRELOAD) begin
         rx_in_valid = 1'b1;
         rx_in_data = preload_char(state.idx);
      end else if (state.console_open) begin
         rx_in_valid = sim_console_in.valid;
         rx_in_data = sim_console_in.data;
      end else if (state.link_open) begin
         rx_in_valid = jtag_rx_in.valid;
         rx_in_data = jtag_rx_in.data;
      end
   end

   always_comb begin
      next_state = state;
      wr_level_now = LEVEL_W'(tx_count);
      rd_level_now = LEVEL_W'(rx_count);
      rd_space = RD_DEPTH_LVL - (LEVEL_W+1)'(rx_count);
      wr_accept = bus_wr_valid_in && tx_in_ready;
      // Read queue level one edge ahead, so both ready outputs come from flops
      rx_next_count = (LEVEL_W+1)'(rx_count) + (LEVEL_W+1)'(rx_in_valid && rx_in_ready)
         - (LEVEL_W+1)'(rx_out_valid && bus_rd_pop_in);

      if (state.phase == ST_PRELOAD && rx_in_ready) begin
         next_state.idx = state.idx + 1'b1;
         if (next_state.idx == PRELOAD_END) begin
            next_state.phase = ST_RUN;
         end
      end
      next_state.link_open = (next_state.phase == ST_RUN)
         && (SIM_MODE != SIM_INTERACTIVE);
      next_state.console_open = (next_state.phase == ST_RUN)
         && (SIM_MODE == SIM_INTERACTIVE);
      next_state.link_ready = next_state.link_open && (rx_next_count != RD_DEPTH_LVL);
      next_state.console_ready = next_state.console_open
         && (rx_next_count != RD_DEPTH_LVL);

      // Sim echo valid is held low when SIM_MODE is left at none; echo data still follows accepted writes
      next_state.echo.valid = wr_accept && (SIM_MODE != SIM_NONE);
      next_state.echo.data = wr_accept ? bus_wr_data_in[CHAR_W-1:0] : state.echo.data;

      // Level-based request: drops by itself once the condition clears
      next_state.irq = (wr_level_now <= wr_threshold_in)
         || (rd_space <= {1'b0, rd_threshold_in});
      next_state.wr_level = wr_level_now;
      next_state.rd_level = rd_level_now;
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= '0;
         state.phase <= DO_PRELOAD ? ST_PRELOAD : ST_RUN;
         state.link_open <= (SIM_MODE != SIM_INTERACTIVE) && !DO_PRELOAD;
         state.console_open <= (SIM_MODE == SIM_INTERACTIVE);
         state.link_ready <= (SIM_MODE != SIM_INTERACTIVE) && !DO_PRELOAD;
         state.console_ready <= (SIM_MODE == SIM_INTERACTIVE);
      end else begin
         state <= next_state;
      end
   end

   assign bus_wr_ready_out = tx_in_ready;
   assign bus_rd_valid_out = rx_out_valid;
   assign bus_rd_data_out = {DATA_PAD, rx_out_data};
   assign jtag_tx_out.valid = tx_out_valid;
   assign jtag_tx_out.data = tx_out_data;
   assign jtag_rx_ready_out = state.link_ready;
   assign sim_console_ready_out = state.console_ready;
   assign wr_level_out = state.wr_level;
   assign rd_level_out = state.rd_level;
   assign irq_out = state.irq;
   assign sim_echo_out = state.echo;

endmodule : jtag_char_fifo_pair

/* File: verif/jtag_char_fifo_pair_assertions.sv */
`timescale 1ns/1ns
module jtag_char_fifo_pair_checker
   import jtag_char_fifo_pkg::*;
#(
   parameter int RD_DEPTH_REQ = DEPTH_DEFAULT,
   parameter sim_console_t SIM_MODE = SIM_NONE
) (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic bus_wr_valid_in,
   input wire logic [DATA_W-1:0] bus_wr_data_in,
   input wire logic bus_wr_ready_out,
   input wire logic bus_rd_valid_out,
   input wire logic [DATA_W-1:0] bus_rd_data_out,
   input wire logic bus_rd_pop_in,
   input wire char_beat_t jtag_tx_out,
   input wire logic jtag_tx_ready_in,
   input wire logic [LEVEL_W-1:0] wr_threshold_in,
   input wire logic [LEVEL_W-1:0] rd_threshold_in,
   input wire logic [LEVEL_W-1:0] wr_level_out,
   input wire logic [LEVEL_W-1:0] rd_level_out,
   input wire logic irq_out,
   input wire char_beat_t sim_echo_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   logic low_cond;
   logic tx_take;
   logic [CHAR_W-1:0] wr_byte;
   assign wr_byte = bus_wr_data_in[CHAR_W-1:0];
   assign tx_take = jtag_tx_out.valid && jtag_tx_ready_in;
   // Free space counts against the rounded depth that is really built
   assign low_cond = wr_level_out <= wr_threshold_in ||
      (LEVEL_W'(legal_depth(RD_DEPTH_REQ)) - rd_level_out) <= rd_threshold_in;
   // Levels lag the queue counts, so irq is only judged once they have settled
   sequence quiet3;
      ($stable(wr_level_out) && $stable(rd_level_out) && $stable(wr_threshold_in)
         && $stable(rd_threshold_in))[*3];
   endsequence
   sequence wr_take;
      bus_wr_valid_in && bus_wr_ready_out;
   endsequence
   a_irq_set: assert property (quiet3 ##0 low_cond |-> irq_out)
      else $error("irq low while a queue is at threshold");
   a_irq_clear: assert property (quiet3 ##0 !low_cond |-> !irq_out)
      else $error("irq high with both queues away from threshold");
   a_full_holds: assert property (!bus_wr_ready_out && !tx_take && !$past(tx_take)
      |=> !bus_wr_ready_out)
      else $error("write ready rose without any drain");
   a_tx_hold: assert property (tx_take == 0 && jtag_tx_out.valid
      |=> jtag_tx_out.valid && $stable(jtag_tx_out.data))
      else $error("link head changed before it was taken");
   a_rd_hold: assert property (bus_rd_valid_out && !bus_rd_pop_in
      |=> bus_rd_valid_out && $stable(bus_rd_data_out))
      else $error("read head changed without a pop");
   a_rd_pad: assert property (bus_rd_valid_out
      |-> bus_rd_data_out[DATA_W-1:CHAR_W] == DATA_PAD)
      else $error("read word upper bits not zero");
   a_wr_to_tx: assert property (wr_take |-> ##[2:3] jtag_tx_out.valid)
      else $error("accepted byte never reached the link head");
   a_echo_byte: assert property (wr_take
      |=> sim_echo_out.valid == (SIM_MODE != SIM_NONE)
      && sim_echo_out.data == $past(wr_byte))
      else $error("accepted write not echoed");
endmodule : jtag_char_fifo_pair_checker

bind jtag_char_fifo_pair jtag_char_fifo_pair_checker #(.RD_DEPTH_REQ(RD_DEPTH_REQ),
   .SIM_MODE(SIM_MODE)) u_chk (
   .clk_sys_in, .sys_rst_in, .bus_wr_valid_in, .bus_wr_data_in, .bus_wr_ready_out,
   .bus_rd_valid_out, .bus_rd_data_out, .bus_rd_pop_in, .jtag_tx_out, .jtag_tx_ready_in,
   .wr_threshold_in, .rd_threshold_in, .wr_level_out, .rd_level_out, .irq_out,
   .sim_echo_out);

/* File: verif/bus_master_model.sv */
`timescale 1ns/1ns
module bus_master_model
   import jtag_char_fifo_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic bus_wr_ready_in,
   input wire logic bus_rd_valid_in,
   input wire logic [DATA_W-1:0] bus_rd_data_in,
   output logic bus_wr_valid_out,
   output logic [DATA_W-1:0] bus_wr_data_out,
   output logic bus_rd_pop_out
);
   initial begin
      bus_wr_valid_out = 1'b0;
      bus_wr_data_out = '0;
      bus_rd_pop_out = 1'b0;
   end
   // Junk in the upper bits: only the low byte may be stored
   task put(input logic [7:0] v, input int tries, output bit ok);
      bus_wr_valid_out <= 1'b1;
      bus_wr_data_out <= {24'hC3A55A, v};
      ok = 1'b0;
      repeat (tries) if (!ok) begin
         @(posedge clk_sys_in);
         ok = (bus_wr_ready_in === 1'b1);
      end
   endtask : put
   // Released data lines do not keep the last value
   task wr_idle;
      bus_wr_valid_out <= 1'b0;
      bus_wr_data_out <= ~bus_wr_data_out;
   endtask : wr_idle
   task get(output logic [31:0] v);
      bus_rd_pop_out <= 1'b1;
      do @(posedge clk_sys_in); while (bus_rd_valid_in !== 1'b1);
      v = bus_rd_data_in;
   endtask : get
   task rd_idle;
      bus_rd_pop_out <= 1'b0;
   endtask : rd_idle
endmodule : bus_master_model

/* File: verif/tb_jtag_char_fifo_pair.sv */
`timescale 1ns/1ns
module tb_jtag_char_fifo_pair
   import jtag_char_fifo_pkg::*;
;
   logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, tx_rdy = 1'b0;
   logic pv, cv, crdy, crxr, ppop = 1'b0;
   logic [31:0] pd, cd;
   logic [15:0] pl, cl;
   char_beat_t con = '0;
   logic wv, rv, pop, wrdy, rxr, irq;
   logic [31:0] wd, rd, w;
   char_beat_t tx, echo, rx = '0;
   logic [15:0] wthr = 16'h0002, rthr = 16'h0001, wl, rl;
   logic [7:0] b;
   bit ok;
   int err_count = 0, num_checks = 0, cyc = 0;
   always #2 clk_sys_in = ~clk_sys_in;
   jtag_char_fifo_pair #(.WR_DEPTH_REQ(8), .RD_DEPTH_REQ(8), .SIM_MODE(SIM_OUTPUT)) u_dut (
      .clk_sys_in, .sys_rst_in, .bus_wr_valid_in(wv), .bus_wr_data_in(wd),
      .bus_wr_ready_out(wrdy), .bus_rd_valid_out(rv), .bus_rd_data_out(rd),
      .bus_rd_pop_in(pop), .jtag_tx_out(tx), .jtag_tx_ready_in(tx_rdy), .jtag_rx_in(rx),
      .jtag_rx_ready_out(rxr), .wr_threshold_in(wthr), .rd_threshold_in(rthr),
      .wr_level_out(wl), .rd_level_out(rl), .irq_out(irq), .sim_console_in('0),
      .sim_console_ready_out(), .sim_echo_out(echo));
   bus_master_model u_bm (.clk_sys_in, .bus_wr_ready_in(wrdy), .bus_rd_valid_in(rv),
      .bus_rd_data_in(rd), .bus_wr_valid_out(wv), .bus_wr_data_out(wd), .bus_rd_pop_out(pop));
   // Preload source: read queue holds the string after every reset
   jtag_char_fifo_pair #(.RD_DEPTH_REQ(8), .PRELOAD_EN(1'b1), .PRELOAD_LEN(3),
      .PRELOAD_TEXT("xyz")) u_pre (
      .clk_sys_in, .sys_rst_in, .bus_wr_valid_in(1'b0), .bus_wr_data_in(32'h00000000),
      .bus_wr_ready_out(), .bus_rd_valid_out(pv), .bus_rd_data_out(pd), .bus_rd_pop_in(ppop),
      .jtag_tx_out(), .jtag_tx_ready_in(1'b0), .jtag_rx_in('0), .jtag_rx_ready_out(),
      .wr_threshold_in(wthr), .rd_threshold_in(rthr), .wr_level_out(), .rd_level_out(pl),
      .irq_out(), .sim_console_in('0), .sim_console_ready_out(), .sim_echo_out());
   // Live console: preload and link traffic must both be ignored
   jtag_char_fifo_pair #(.RD_DEPTH_REQ(8), .SIM_MODE(SIM_INTERACTIVE), .PRELOAD_EN(1'b1),
      .PRELOAD_LEN(3), .PRELOAD_TEXT("xyz")) u_con (
      .clk_sys_in, .sys_rst_in, .bus_wr_valid_in(1'b0), .bus_wr_data_in(32'h00000000),
      .bus_wr_ready_out(), .bus_rd_valid_out(cv), .bus_rd_data_out(cd), .bus_rd_pop_in(1'b0),
      .jtag_tx_out(), .jtag_tx_ready_in(1'b0), .jtag_rx_in(rx), .jtag_rx_ready_out(crxr),
      .wr_threshold_in(wthr), .rd_threshold_in(rthr), .wr_level_out(), .rd_level_out(cl),
      .irq_out(), .sim_console_in(con), .sim_console_ready_out(crdy), .sim_echo_out());
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task wt(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask : wt
   task rx_push(input logic [7:0] v);
      rx <= '{1'b1, v};
      do @(posedge clk_sys_in); while (rxr !== 1'b1);
   endtask : rx_push
   task tx_pull(output logic [7:0] v);
      tx_rdy <= 1'b1;
      do @(posedge clk_sys_in); while (tx.valid !== 1'b1);
      v = tx.data;
   endtask : tx_pull
   task wrap_up;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   // Whole run needs about a hundred cycles
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         wrap_up();
      end
   end
   initial begin
      wt(2);
      sys_rst_in <= 1'b0;
      wt(1);
      chk("wr_level", 0, wl);
      chk("rd_valid", 0, rv);
      chk("wr_ready", 1, wrdy);
      wt(1);
      chk("irq", 1, irq);
      $display("reset test done");
      for (int i = 0; i < 8; i++) u_bm.put(8'h41 + i, 50, ok);
      u_bm.put(8'h7E, 4, ok);
      u_bm.wr_idle();
      chk("refused", 0, ok);
      chk("echo_data", 8'h48, echo.data);
      wt(3);
      chk("wr_level", 8, wl);
      chk("irq", 0, irq);
      for (int i = 0; i < 8; i++) begin
         tx_pull(b);
         chk("tx_byte", 8'h41 + i, b);
         if (i == 4 || i == 5) begin
            tx_rdy <= 1'b0;
            wt(3);
            chk("irq", i == 5, irq);
         end
      end
      tx_rdy <= 1'b0;
      $display("write queue test done");
      wthr <= 16'h0000;
      for (int i = 0; i < 3; i++) u_bm.put(8'h30 + i, 50, ok);
      u_bm.wr_idle();
      for (int i = 0; i < 8; i++) begin
         rx_push(8'h61 + i);
         if (i == 5 || i == 6) begin
            rx <= '{1'b0, ~rx.data};
            wt(3);
            chk("irq", i == 6, irq);
         end
      end
      rx <= '{1'b0, ~rx.data};
      wt(3);
      chk("rd_level", 8, rl);
      chk("rx_ready", 0, rxr);
      chk("wr_level", 3, wl);
      for (int i = 0; i < 8; i++) begin
         u_bm.get(w);
         chk("rd_word", {24'h000000, 8'h61 + 8'(i)}, w);
      end
      u_bm.rd_idle();
      $display("read queue test done");
      chk("pre_level", 3, pl);
      chk("pre_valid", 1, pv);
      ppop <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_sys_in);
         chk("pre_word", {24'h000000, 8'h78 + 8'(i)}, pd);
      end
      ppop <= 1'b0;
      chk("con_level", 0, cl);
      chk("con_link", 0, crxr);
      con <= '{1'b1, 8'h7A};
      do @(posedge clk_sys_in); while (crdy !== 1'b1);
      con <= '0;
      wt(3);
      chk("con_valid", 1, cv);
      chk("con_word", {24'h000000, 8'h7A}, cd);
      chk("con_level", 1, cl);
      $display("simulation source test done");
      sys_rst_in <= 1'b1;
      wt(1);
      chk("wr_level", 0, wl);
      chk("tx_valid", 0, tx.valid);
      chk("irq", 0, irq);
      sys_rst_in <= 1'b0;
      wt(5);
      chk("pre_level", 3, pl);
      $display("mid-run reset test done");
      wrap_up();
   end
endmodule : tb_jtag_char_fifo_pair
